/* common/wdt_pkg.sv */
// Purpose: Shared constants and types for the windowed watchdog timer.
// Assumes: AHB-Lite register access, 32-bit word registers, one 250 MHz clock.
// Notes: The slow clock is an input level, synchronised inside the block.
package wdt_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_RESTART_CMD = 8'h00;
  localparam logic [7:0] OFS_MODE_ONCE = 8'h04;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h08;

  // Restart command fields.
  localparam logic [7:0] RESTART_KEY = 8'hA5;
  localparam int KEY_LSB = 24;
  localparam int RESTART_BIT = 0;

  // Mode register fields.
  localparam int LOAD_LSB = 0;
  localparam int FIEN_BIT = 12;
  localparam int RSTEN_BIT = 13;
  localparam int PROC_BIT = 14;
  localparam int DIS_BIT = 15;
  localparam int DELTA_LSB = 16;
  localparam int DBG_BIT = 28;
  localparam int IDLE_BIT = 29;
  localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
  localparam logic [31:0] MODE_MASK = 32'h3FFF_FFFF;

  // Status fields.
  localparam int UNF_BIT = 0;
  localparam int ERR_BIT = 1;

  // Slow clock prescaler.
  localparam int PRESCALE_DIV = 128;
  localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE_DIV - 1);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [31:0] mode;
    logic mode_written;
    logic [11:0] count;
    logic [6:0] prescale;
    logic slow_s1;
    logic slow_s2;
    logic slow_d;
    logic dbg_s1;
    logic dbg_s2;
    logic idle_s1;
    logic idle_s2;
    logic unf_flag;
    logic err_flag;
    logic irq;
    logic fault_rst;
    logic proc_rst;
    logic dp_wr;
    logic dp_rd;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } wdt_state_s;

endpackage

/* verilog/windowed_watchdog_timer.sv */
// Purpose: Windowed watchdog with keyed restart, write-once mode and read-clear status.
// Assumes: slow_clk, debug_state and idle_state come from other domains.
// Notes: hrdata and the fault outputs are registered; hreadyout and hresp are tied, so the slave always answers OKAY without waits.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps

module windowed_watchdog_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System state inputs
  input wire logic slow_clk,
  input wire logic debug_state,
  input wire logic idle_state,
  // Fault outputs
  output logic wdt_irq,
  output logic wdt_fault,
  output logic wdt_proc_only
);

  wdt_state_s st_r;
  wdt_state_s st_nxt;

  logic addr_ok;
  logic wr_cmd;
  logic wr_mode;
  logic rd_flags;
  logic restart_req;
  logic restart_ok;
  logic restart_bad;
  logic slow_edge;
  logic halted;
  logic tick;
  logic underflow;
  logic fault_evt;
  logic reload;

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    st_nxt = st_r;
    // Data phase decode of the previous address phase.
    wr_cmd = st_r.dp_wr && (st_r.dp_addr == OFS_RESTART_CMD)
             && (hwdata[KEY_LSB +: 8] == RESTART_KEY);
    wr_mode = st_r.dp_wr && (st_r.dp_addr == OFS_MODE_ONCE) && !st_r.mode_written;
    rd_flags = st_r.dp_rd && (st_r.dp_addr == OFS_FAULT_FLAGS);
    restart_req = wr_cmd && hwdata[RESTART_BIT];
    // The window check applies even while disabled, as an error is still reported.
    restart_ok = restart_req && (st_r.count <= st_r.mode[DELTA_LSB +: 12]);
    restart_bad = restart_req && !restart_ok;
    slow_edge = st_r.slow_s2 && !st_r.slow_d;
    halted = st_r.mode[DIS_BIT]
             || (st_r.mode[DBG_BIT] && st_r.dbg_s2)
             || (st_r.mode[IDLE_BIT] && st_r.idle_s2);
    tick = slow_edge && !halted && (st_r.prescale == PRESCALE_LAST);
    underflow = tick && (st_r.count == 12'h000);
    fault_evt = underflow || restart_bad;
    reload = restart_ok || wr_mode;

    st_nxt.slow_s1 = slow_clk;
    st_nxt.slow_s2 = st_r.slow_s1;
    st_nxt.slow_d = st_r.slow_s2;
    st_nxt.dbg_s1 = debug_state;
    st_nxt.dbg_s2 = st_r.dbg_s1;
    st_nxt.idle_s1 = idle_state;
    st_nxt.idle_s2 = st_r.idle_s1;

    if (wr_mode) begin
      st_nxt.mode = hwdata & MODE_MASK;
      st_nxt.mode_written = 1'b1;
    end

    if (reload) begin
      st_nxt.count = wr_mode ? hwdata[LOAD_LSB +: 12] : st_r.mode[LOAD_LSB +: 12];
      st_nxt.prescale = 7'h00;
    end else if (slow_edge && !halted) begin
      st_nxt.prescale = st_r.prescale + 7'h01;
      if (tick) begin
        // Underflow wraps to all ones; the flag records it.
        st_nxt.count = st_r.count - 12'h001;
      end
    end

    // Read clears, but a fault in the same cycle wins.
    if (rd_flags) begin
      st_nxt.unf_flag = 1'b0;
      st_nxt.err_flag = 1'b0;
      st_nxt.irq = 1'b0;
      st_nxt.fault_rst = 1'b0;
      st_nxt.proc_rst = 1'b0;
    end
    if (underflow) begin
      st_nxt.unf_flag = 1'b1;
    end
    if (restart_bad) begin
      st_nxt.err_flag = 1'b1;
    end
    if (fault_evt && st_r.mode[FIEN_BIT]) begin
      st_nxt.irq = 1'b1;
    end
    if (fault_evt && st_r.mode[RSTEN_BIT]) begin
      st_nxt.fault_rst = 1'b1;
      st_nxt.proc_rst = st_r.mode[PROC_BIT];
    end

    // Address phase capture.
    st_nxt.dp_wr = addr_ok && hwrite;
    st_nxt.dp_rd = addr_ok && !hwrite;
    st_nxt.dp_addr = haddr[7:0];
    st_nxt.hrdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        OFS_MODE_ONCE: st_nxt.hrdata = st_nxt.mode;
        OFS_FAULT_FLAGS: begin
          st_nxt.hrdata[UNF_BIT] = st_nxt.unf_flag;
          st_nxt.hrdata[ERR_BIT] = st_nxt.err_flag;
        end
        default: st_nxt.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.mode <= MODE_RESET;
      st_r.count <= MODE_RESET[11:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdt_irq = st_r.irq;
  assign wdt_fault = st_r.fault_rst;
  assign wdt_proc_only = st_r.proc_rst;

  sequence keyed_restart_s;
    st_r.dp_wr && st_r.dp_addr == OFS_RESTART_CMD && hwdata[31:24] == RESTART_KEY && hwdata[0];
  endsequence

  bad_key_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.dp_wr && st_r.dp_addr == OFS_RESTART_CMD && hwdata[31:24] != RESTART_KEY && !tick)
    |=> $stable(st_r.count))
    else $error("Badly keyed write changed the counter.");

  no_restart_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.dp_wr && st_r.dp_addr == OFS_RESTART_CMD && !hwdata[0] && !tick && !wr_mode)
    |=> $stable(st_r.count))
    else $error("Restart bit zero disturbed the counter.");

  window_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (keyed_restart_s and (st_r.count <= st_r.mode[27:16]))
    |=> (st_r.count == st_r.mode[11:0]) && (st_r.prescale == 7'h00))
    else $error("Restart inside window did not reload.");

  window_error_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (keyed_restart_s and (st_r.count > st_r.mode[27:16])) |=> st_r.err_flag)
    else $error("Restart outside window was not an error.");

  disable_stops_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.mode[15] && !reload) |=> $stable(st_r.count))
    else $error("Counter moved while disabled.");

  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.irq && !st_r.mode[12]) |=> !st_r.irq)
    else $error("Interrupt raised with enable clear.");

  reset_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_evt && st_r.mode[13]) |=> (wdt_fault && wdt_proc_only == $past(st_r.mode[14])))
    else $error("Fault reset request missing or wrong scope.");

  underflow_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    underflow |=> st_r.unf_flag)
    else $error("Underflow flag not set.");

  read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_flags && !fault_evt) |=> (!st_r.unf_flag && !st_r.err_flag && !wdt_irq && !wdt_fault))
    else $error("Status read did not clear the fault state.");

  mode_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.mode_written |=> $stable(st_r.mode))
    else $error("Mode register changed after first write.");

  // A prescaler step that no reload overrides.
  sequence free_step_s;
    slow_edge && !halted && !reload;
  endsequence

  // A fault followed by its flag standing in the next cycle.
  sequence fault_seen_s;
    fault_evt ##1 (st_r.unf_flag || st_r.err_flag);
  endsequence

  // The checks below pin down each step of the counter, so a broken
  // enable or a wrong priority shows up at the cycle where it happens.
  load_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode |=> (st_r.count == $past(hwdata[LOAD_LSB +: 12])) && (st_r.prescale == 7'h00))
    else $error("Mode write did not load the counter.");

  irq_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_evt && st_r.mode[FIEN_BIT]) |=> wdt_irq)
    else $error("Enabled fault did not raise the interrupt.");

  irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_irq && !rd_flags) |=> wdt_irq)
    else $error("Interrupt dropped without a status read.");

  no_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.fault_rst && !st_r.mode[RSTEN_BIT]) |=> !wdt_fault)
    else $error("Fault reset raised with reset enable clear.");

  fault_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_fault && !rd_flags) |=> wdt_fault)
    else $error("Fault reset request dropped without a status read.");

  scope_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_fault && !rd_flags && !fault_evt) |=> $stable(wdt_proc_only))
    else $error("Reset scope changed while a request stood.");

  cmd_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && haddr[7:0] == OFS_RESTART_CMD) |=> (hrdata == 32'h0000_0000))
    else $error("Restart command read returned data.");

  bad_key_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.dp_wr && st_r.dp_addr == OFS_RESTART_CMD && hwdata[KEY_LSB +: 8] != RESTART_KEY && !underflow)
    |=> $stable(st_r.err_flag))
    else $error("Badly keyed write changed the error flag.");

  restart_prescale_a: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_ok |=> (st_r.prescale == 7'h00))
    else $error("Valid restart did not clear the prescaler.");

  debug_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.mode[DBG_BIT] && st_r.dbg_s2 && !reload) |=> $stable(st_r.count) && $stable(st_r.prescale))
    else $error("Counter moved in debug state with debug halt set.");

  idle_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.mode[IDLE_BIT] && st_r.idle_s2 && !reload) |=> $stable(st_r.count) && $stable(st_r.prescale))
    else $error("Counter moved in idle state with idle halt set.");

  error_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_bad |=> st_r.err_flag)
    else $error("Restart error flag not set.");

  unf_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.unf_flag && !rd_flags) |=> st_r.unf_flag)
    else $error("Underflow flag cleared without a read.");

  err_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.err_flag && !rd_flags) |=> st_r.err_flag)
    else $error("Error flag cleared without a read.");

  unf_only_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.unf_flag && !underflow) |=> !st_r.unf_flag)
    else $error("Underflow flag set without an underflow.");

  err_only_bad_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.err_flag && !restart_bad) |=> !st_r.err_flag)
    else $error("Error flag set without a restart error.");

  prescale_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (free_step_s ##0 (st_r.prescale != PRESCALE_LAST))
    |=> (st_r.prescale == $past(st_r.prescale) + 7'h01) && $stable(st_r.count))
    else $error("Prescaler step wrong between ticks.");

  tick_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && !reload) |=> (st_r.count == $past(st_r.count) - 12'h001))
    else $error("Counter did not step down on a tick.");

  count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!slow_edge && !reload) |=> $stable(st_r.count))
    else $error("Counter moved without a slow clock edge.");

  read_after_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_seen_s ##0 (rd_flags && !fault_evt))
    |=> (!st_r.unf_flag && !st_r.err_flag && !wdt_irq && !wdt_fault))
    else $error("Read after a fault left fault state standing.");

  // Reserved mode bits are masked on write, so they must read as zero.
  mode_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.mode[31:30] == 2'h0)
    else $error("Reserved mode bits were set.");

endmodule // windowed_watchdog_timer

/* dv/wdt_far_side.sv */
// Purpose: Far-side model supplying the slow clock and system state levels.
// Assumes: The slow clock runs free, as an oscillator would.
// Notes: Eight fast cycles per slow period keep underflow runs short.
`timescale 1ns/10ps
module wdt_far_side (
  // Fast clock
  input wire logic hclk,
  // Bench requests for the system levels
  input wire logic debug_req,
  input wire logic idle_req,
  // System levels
  output logic slow_clk,
  output logic debug_state,
  output logic idle_state
);
  initial begin
    slow_clk = 1'b0;
    forever begin
      repeat (4) @(posedge hclk);
      slow_clk <= ~slow_clk;
    end
  end

  // The state lines follow the bench a clock later, as a processor's would.
  always @(posedge hclk) begin
    debug_state <= debug_req;
    idle_state <= idle_req;
  end
endmodule // wdt_far_side

/* dv/windowed_watchdog_timer_test.sv */
// Purpose: Self-checking bench for the windowed watchdog timer.
// Assumes: Zero-wait AHB-Lite slave, registered fault outputs.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/10ps
module windowed_watchdog_timer_test;
  import wdt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow_clk, debug_state, idle_state;
  logic wdt_irq, wdt_fault, wdt_proc_only, debug_req, idle_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  int error_cnt = 0;
  int checks_done = 0;
  localparam logic [31:0] MODE_VAL = 32'h0001_7005;
  // Both halts set, reset to all, no interrupt, open window, load value 3.
  localparam logic [31:0] HALT_MODE = 32'h3FFF_2003;

  windowed_watchdog_timer windowed_watchdog_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slow_clk(slow_clk),
    .debug_state(debug_state), .idle_state(idle_state), .wdt_irq(wdt_irq), .wdt_fault(wdt_fault),
    .wdt_proc_only(wdt_proc_only));
  wdt_far_side wdt_far_side_i (.hclk(hclk), .debug_req(debug_req), .idle_req(idle_req), .slow_clk(slow_clk),
    .debug_state(debug_state), .idle_state(idle_state));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reset_values();
    xfer(1'b0, OFS_MODE_ONCE, 32'h0000_0000, rd);
    chk("mode reset", MODE_RESET, rd);
    xfer(1'b0, OFS_FAULT_FLAGS, 32'h0000_0000, rd);
    chk("status reset", 32'h0000_0000, rd);
  endtask

  task automatic mode_once();
    xfer(1'b1, OFS_MODE_ONCE, MODE_VAL, rd);
    xfer(1'b1, OFS_MODE_ONCE, 32'h0000_0FFF, rd);
    xfer(1'b0, OFS_MODE_ONCE, 32'h0000_0000, rd);
    chk("mode once", MODE_VAL, rd);
  endtask

  task automatic window_error();
    xfer(1'b1, OFS_RESTART_CMD, 32'h5A00_0001, rd);
    xfer(1'b1, OFS_RESTART_CMD, 32'hA500_0000, rd);
    repeat (3) @(posedge hclk);
    chk("no fault", 32'h0000_0000, {31'h0000_0000, wdt_fault});
    xfer(1'b1, OFS_RESTART_CMD, 32'hA500_0001, rd);
    repeat (3) @(posedge hclk);
    chk("irq", 32'h0000_0001, {31'h0000_0000, wdt_irq});
    chk("fault", 32'h0000_0001, {31'h0000_0000, wdt_fault});
    chk("proc only", 32'h0000_0001, {31'h0000_0000, wdt_proc_only});
    xfer(1'b0, OFS_FAULT_FLAGS, 32'h0000_0000, rd);
    chk("error flag", 32'h0000_0002, rd);
    repeat (2) @(posedge hclk);
    chk("cleared", 32'h0000_0000, {30'h0000_0000, wdt_irq, wdt_fault});
  endtask

  task automatic underflow();
    int n;
    n = 0;
    while (wdt_irq !== 1'b1 && n < 12000) begin
      @(posedge hclk);
      n++;
    end
    chk("underflow irq", 32'h0000_0001, {31'h0000_0000, wdt_irq});
    xfer(1'b0, OFS_FAULT_FLAGS, 32'h0000_0000, rd);
    chk("underflow flag", 32'h0000_0001, rd);
  endtask

  task automatic halt_and_scope();
    int n;
    n = 0;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk("reset clears fault", 32'h0000_0000, {30'h0000_0000, wdt_irq, wdt_fault});
    debug_req <= 1'b1;
    repeat (6) @(posedge hclk);
    xfer(1'b1, OFS_MODE_ONCE, HALT_MODE, rd);
    repeat (5000) @(posedge hclk);
    chk("debug halt", 32'h0000_0000, {31'h0000_0000, wdt_fault});
    debug_req <= 1'b0;
    idle_req <= 1'b1;
    repeat (5000) @(posedge hclk);
    chk("idle halt", 32'h0000_0000, {31'h0000_0000, wdt_fault});
    idle_req <= 1'b0;
    while (wdt_fault !== 1'b1 && n < 6000) begin
      @(posedge hclk);
      n++;
    end
    chk("all reset fault", 32'h0000_0001, {31'h0000_0000, wdt_fault});
    chk("all reset scope", 32'h0000_0000, {31'h0000_0000, wdt_proc_only});
    chk("irq disabled", 32'h0000_0000, {31'h0000_0000, wdt_irq});
    xfer(1'b0, OFS_FAULT_FLAGS, 32'h0000_0000, rd);
    chk("halt underflow flag", 32'h0000_0001, rd);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    debug_req = 1'b0;
    idle_req = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    mode_once();
    window_error();
    underflow();
    halt_and_scope();
    final_report();
  end

  // A hang in any wait loop ends here rather than running forever.
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    final_report();
  end
endmodule // windowed_watchdog_timer_test
